// *** rtl/output_clip_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the clip limiter
`ifndef OUTPUT_CLIP_REGS_SVH
`define OUTPUT_CLIP_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CLIP_LIMITS 8'h00
`define REG_OUT_CONFIG 8'h04
`define REG_STATUS 8'h08
`define REG_THRESHOLDS 8'h0C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CLIP_UP_LSB 0
`define CLIP_LOW_LSB 8
`define CFG_MODE_LSB 0
`define CFG_DIAG_LSB 2
`define CFG_SETPOINT_BIT 5
`define CFG_TRIM_LSB 8
`define DIAG_SHORT_EN_BIT 0
`define STAT_CLIP_HI_BIT 16
`define STAT_CLIP_LO_BIT 17
`define STAT_RUN_BIT 18
`define STAT_PEND_BIT 19
`define THR_LOW_LSB 16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_UP_LIM 7'h7F
`define RST_LOW_LIM 7'h00
`define RST_MODE 2'h0
`define RST_DIAG 3'h1
`define RST_SETPOINT 1'b0
`define RST_TRIM 4'h0

// ----------------------------------------------------------------------
// Threshold padding, trim ordering and timing
// ----------------------------------------------------------------------
`define UP_LEAD 2'h3
`define UP_TAIL 5'h1F
`define LOW_LEAD 2'h0
`define LOW_TAIL 5'h00
`define TRIM_ORDER_XOR 4'h7
`define SYS_CLK_KHZ 200000
`define OSC_FREQ_KHZ 512
`define OSC_TICK_CYCLES (`SYS_CLK_KHZ / `OSC_FREQ_KHZ)

`endif

// *** rtl/output_clip_pkg.sv ***
// Types shared by the clip limiter modules
package output_clip_pkg;

  typedef enum logic [1:0] {
    MODE_RATIOMETRIC = 2'b00,
    MODE_ABSOLUTE = 2'b01,
    MODE_ZERO_TO_ONE_V = 2'b10,
    MODE_DIGITAL = 2'b11
  } out_mode_t;

  typedef enum logic [1:0] {
    PWR_HOLD = 2'b00,
    PWR_RUN = 2'b01
  } pwr_state_t;

endpackage : output_clip_pkg

// *** rtl/clip_compare.sv ***
// Threshold assembly and unsigned clip of the corrected bridge value
`timescale 1ns/10ps
`default_nettype none
`include "output_clip_regs.svh"

module clip_compare (
  // Limits
  input wire logic [6:0] up_clip_limit,
  input wire logic [6:0] low_clip_limit,
  // Value
  input wire logic [13:0] bridge_value,
  // Result
  output logic [13:0] upper_threshold,
  output logic [13:0] lower_threshold,
  output logic [13:0] clipped_value,
  output logic above_upper,
  output logic below_lower
);

  always_comb begin
    upper_threshold = {`UP_LEAD, up_clip_limit, `UP_TAIL};
    lower_threshold = {`LOW_LEAD, low_clip_limit, `LOW_TAIL};
    // Both checks run every evaluation, unsigned
    above_upper = bridge_value > upper_threshold;
    below_lower = bridge_value < lower_threshold;
    if (above_upper) begin
      clipped_value = upper_threshold;
    end else if (below_lower) begin
      clipped_value = lower_threshold;
    end else begin
      clipped_value = bridge_value;
    end
  end

endmodule : clip_compare
`default_nettype wire

// *** rtl/power_on_clock.sv ***
// Supply-good synchroniser, reset release and internal conversion clock enable
`timescale 1ns/10ps
`default_nettype none
`include "output_clip_regs.svh"

module power_on_clock #(
  parameter int TICK_CYCLES = `OSC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Supply comparator
  input wire logic supply_ok,
  // Status
  output logic running,
  output logic core_tick
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    output_clip_pkg::pwr_state_t state;
    logic [15:0] div;
    logic tick;
  } por_state_t;

  por_state_t s_q;
  por_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = supply_ok;
    s_d.sync2 = s_q.sync1;
    s_d.tick = 1'b0;
    case (s_q.state)
      output_clip_pkg::PWR_HOLD: begin
        s_d.div = 16'h0000;
        if (s_q.sync2) begin
          s_d.state = output_clip_pkg::PWR_RUN;
        end
      end
      output_clip_pkg::PWR_RUN: begin
        if (!s_q.sync2) begin
          s_d.state = output_clip_pkg::PWR_HOLD;
        end else if (s_q.div == 16'(TICK_CYCLES - 1)) begin
          s_d.div = 16'h0000;
          s_d.tick = 1'b1;
        end else begin
          s_d.div = s_q.div + 16'h0001;
        end
      end
      default: s_d.state = output_clip_pkg::PWR_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign running = (s_q.state == output_clip_pkg::PWR_RUN);
  assign core_tick = s_q.tick;

endmodule : power_on_clock
`default_nettype wire

// *** rtl/output_clip_limiter.sv ***
// Output clip limiter: thresholds, clipping, output mode and reference controls
// How it works
// - The upper threshold is two ones, the 7-bit upper limit, then five ones.
// - The lower threshold is two zeros, the 7-bit lower limit, then five zeros.
// - Values above the upper threshold give it, below the lower give it, else pass.
// - The same clipped value feeds the analog converter in the three analog modes and the digital output in digital mode.
// - A 12-bit converter code is driven in ratiometric, absolute voltage and 0 to 1 V modes.
// - Output short-current limiting follows bit 0 of the 3-bit diagnostic configuration field.
// - The set-point select bit picks a coarse regulator target of 5.0 V or 5.5 V.
// - Trim codes rank from 0111 lowest, down to 0000, then 1111 down to 1000 highest.
// - In the 0 to 1 V mode the trimmed 1 V reference is the converter's high reference.
// - The trim code also finely adjusts the external regulator set point.
// - Reset releases once supply is good, then the internal clock enable starts.
// - Clock rate sets only update pacing, never the numeric output value.
`timescale 1ns/10ps
`default_nettype none
`include "output_clip_regs.svh"

module output_clip_limiter #(
  parameter int TICK_CYCLES = `OSC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Supply comparator, asynchronous
  input wire logic supply_ok,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Corrected bridge value from signal processing
  input wire logic [13:0] bridge_value,
  input wire logic bridge_valid,
  // Output converter
  output logic [11:0] dac_code,
  output logic dac_load,
  output logic dac_href_1v,
  // Digital output value
  output logic [13:0] digital_value,
  output logic digital_valid,
  // Analog controls
  output logic short_limit_en,
  output logic regulator_target_5v5,
  output logic [3:0] reference_trim_code,
  output logic [3:0] reference_trim_rank,
  output logic [3:0] regulator_fine_rank,
  // Status
  output logic running,
  output logic core_tick
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] up_lim;
    logic [6:0] low_lim;
    output_clip_pkg::out_mode_t mode;
    logic [2:0] diag_cfg;
    logic setpoint_sel;
    logic [3:0] trim;
    logic [13:0] pend_val;
    logic pend;
    logic [13:0] out_val;
    logic clip_hi;
    logic clip_lo;
    logic [11:0] dac;
    logic dac_ld;
    logic [13:0] dig;
    logic dig_vld;
    logic short_en;
    logic href_1v;
    logic target_5v5;
    logic [3:0] trim_rank;
    logic [31:0] rdata;
  } lim_state_t;

  lim_state_t s_q;
  lim_state_t s_d;

  logic [13:0] upper_thr;
  logic [13:0] lower_thr;
  logic [13:0] clipped;
  logic above_upper;
  logic below_lower;
  logic run_w;
  logic tick_w;
  logic analog_mode;

  // ----------------------------------------------------------------------
  // Power-on release and conversion pacing
  // ----------------------------------------------------------------------
  power_on_clock #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_power_on_clock (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .supply_ok(supply_ok),
    .running(run_w),
    .core_tick(tick_w)
  );

  // ----------------------------------------------------------------------
  // Clip comparison
  // ----------------------------------------------------------------------
  // Compares the held sample so the clip flags match what is emitted
  clip_compare u_clip_compare (
    .up_clip_limit(s_q.up_lim),
    .low_clip_limit(s_q.low_lim),
    .bridge_value(s_q.pend_val),
    .upper_threshold(upper_thr),
    .lower_threshold(lower_thr),
    .clipped_value(clipped),
    .above_upper(above_upper),
    .below_lower(below_lower)
  );

  assign analog_mode = (s_q.mode != output_clip_pkg::MODE_DIGITAL);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.dac_ld = 1'b0;
    s_d.dig_vld = 1'b0;
    s_d.rdata = 32'h0000_0000;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `REG_CLIP_LIMITS: begin
          s_d.up_lim = reg_wdata[`CLIP_UP_LSB +: 7];
          s_d.low_lim = reg_wdata[`CLIP_LOW_LSB +: 7];
        end
        `REG_OUT_CONFIG: begin
          s_d.mode = output_clip_pkg::out_mode_t'(reg_wdata[`CFG_MODE_LSB +: 2]);
          s_d.diag_cfg = reg_wdata[`CFG_DIAG_LSB +: 3];
          s_d.setpoint_sel = reg_wdata[`CFG_SETPOINT_BIT];
          s_d.trim = reg_wdata[`CFG_TRIM_LSB +: 4];
        end
        default: begin
          s_d.pend = s_q.pend;
        end
      endcase
    end

    // Register reads, data stand in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        `REG_CLIP_LIMITS: begin
          s_d.rdata[`CLIP_UP_LSB +: 7] = s_q.up_lim;
          s_d.rdata[`CLIP_LOW_LSB +: 7] = s_q.low_lim;
        end
        `REG_OUT_CONFIG: begin
          s_d.rdata[`CFG_MODE_LSB +: 2] = s_q.mode;
          s_d.rdata[`CFG_DIAG_LSB +: 3] = s_q.diag_cfg;
          s_d.rdata[`CFG_SETPOINT_BIT] = s_q.setpoint_sel;
          s_d.rdata[`CFG_TRIM_LSB +: 4] = s_q.trim;
        end
        `REG_STATUS: begin
          s_d.rdata[13:0] = s_q.out_val;
          s_d.rdata[`STAT_CLIP_HI_BIT] = s_q.clip_hi;
          s_d.rdata[`STAT_CLIP_LO_BIT] = s_q.clip_lo;
          s_d.rdata[`STAT_RUN_BIT] = run_w;
          s_d.rdata[`STAT_PEND_BIT] = s_q.pend;
        end
        `REG_THRESHOLDS: begin
          s_d.rdata[13:0] = upper_thr;
          s_d.rdata[`THR_LOW_LSB +: 14] = lower_thr;
        end
        default: begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Capture a new sample; the newest one wins if several arrive per tick
    if (bridge_valid && run_w) begin
      s_d.pend_val = bridge_value;
      s_d.pend = 1'b1;
    end

    // Output update on the conversion tick. The tick only paces the update;
    // the emitted number depends on the sample and limits alone.
    if (tick_w && s_q.pend) begin
      s_d.pend = bridge_valid;
      s_d.out_val = clipped;
      s_d.clip_hi = above_upper;
      s_d.clip_lo = below_lower;
      if (analog_mode) begin
        s_d.dac = clipped[13:2];
        s_d.dac_ld = 1'b1;
      end else begin
        s_d.dig = clipped;
        s_d.dig_vld = 1'b1;
      end
    end

    // Losing supply drops any held sample
    if (!run_w) begin
      s_d.pend = 1'b0;
    end

    // Static analog controls, registered so they never glitch
    s_d.short_en = s_q.diag_cfg[`DIAG_SHORT_EN_BIT];
    s_d.href_1v = (s_q.mode == output_clip_pkg::MODE_ZERO_TO_ONE_V);
    s_d.target_5v5 = s_q.setpoint_sel;
    s_d.trim_rank = s_q.trim ^ `TRIM_ORDER_XOR;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.up_lim <= `RST_UP_LIM;
      s_q.low_lim <= `RST_LOW_LIM;
      s_q.mode <= output_clip_pkg::out_mode_t'(`RST_MODE);
      s_q.diag_cfg <= `RST_DIAG;
      s_q.setpoint_sel <= `RST_SETPOINT;
      s_q.trim <= `RST_TRIM;
      s_q.short_en <= ((`RST_DIAG >> `DIAG_SHORT_EN_BIT) & 3'h1) != 3'h0;
      s_q.trim_rank <= `RST_TRIM ^ `TRIM_ORDER_XOR;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign dac_code = s_q.dac;
  assign dac_load = s_q.dac_ld;
  assign dac_href_1v = s_q.href_1v;
  assign digital_value = s_q.dig;
  assign digital_valid = s_q.dig_vld;
  assign short_limit_en = s_q.short_en;
  assign regulator_target_5v5 = s_q.target_5v5;
  assign reference_trim_code = s_q.trim;
  assign reference_trim_rank = s_q.trim_rank;
  // Regulator fine adjust rides on the same trim ordering as the 1 V reference
  assign regulator_fine_rank = s_q.trim_rank;
  assign running = run_w;
  assign core_tick = tick_w;

endmodule : output_clip_limiter
`default_nettype wire

// *** testbench/output_clip_limiter_sva.sv ***
// Port checker for the output clip limiter, bound to its top module
`timescale 1ns/10ps
`default_nettype none

module output_clip_limiter_chk #(
  parameter int TICK_CYCLES = 4
) (
  // Clock, reset and register writes
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Outputs
  input wire logic [11:0] dac_code,
  input wire logic dac_load,
  input wire logic dac_href_1v,
  input wire logic [13:0] digital_value,
  input wire logic digital_valid,
  input wire logic short_limit_en,
  input wire logic regulator_target_5v5,
  input wire logic [3:0] reference_trim_code,
  input wire logic [3:0] reference_trim_rank,
  input wire logic [3:0] regulator_fine_rank,
  input wire logic running,
  input wire logic core_tick
);
  logic [6:0] up_q;
  logic [6:0] low_q;
  int gap_q;

  // Shadow of the limit fields, so bounds need no peek inside the design
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      up_q <= 7'h7F;
      low_q <= 7'h00;
    end else if (reg_wr && reg_addr == 8'h00) begin
      up_q <= reg_wdata[6:0];
      low_q <= reg_wdata[14:8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b || !running || core_tick) begin
      gap_q <= 0;
    end else begin
      gap_q <= gap_q + 1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  upper_bound_a: assert property (dac_load |-> dac_code <= {2'b11, up_q, 3'b111})
    else $error("dac code above upper threshold");
  lower_bound_a: assert property (dac_load |-> dac_code >= {2'b00, low_q, 3'b000})
    else $error("dac code below lower threshold");
  digital_bounds_a: assert property (digital_valid |->
    digital_value >= {2'b00, low_q, 5'h00} && digital_value <= {2'b11, up_q, 5'h1F})
    else $error("digital value outside thresholds");
  config_follow_a: assert property ((reg_wr && reg_addr == 8'h04) |-> ##2
    (short_limit_en == $past(reg_wdata[2], 2) && regulator_target_5v5 == $past(reg_wdata[5], 2)
    && dac_href_1v == ($past(reg_wdata[1:0], 2) == 2'b10)))
    else $error("analog controls do not follow config");
  trim_rank_a: assert property (
    reference_trim_rank == ($past(reference_trim_code) ^ 4'h7))
    else $error("trim rank order wrong");
  fine_rank_a: assert property (
    regulator_fine_rank == ($past(reference_trim_code) ^ 4'h7))
    else $error("fine regulator rank differs");
  tick_gap_a: assert property (gap_q <= TICK_CYCLES)
    else $error("internal tick missing");
  tick_running_a: assert property (core_tick |-> running)
    else $error("tick while not running");
  single_update_a: assert property (dac_load |=> !dac_load && !digital_valid)
    else $error("second update after one tick");

  cover property (dac_load);
  cover property (digital_valid);
  cover property ($rose(running));
endmodule : output_clip_limiter_chk

bind output_clip_limiter output_clip_limiter_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .dac_code, .dac_load, .dac_href_1v,
  .digital_value, .digital_valid, .short_limit_en, .regulator_target_5v5,
  .reference_trim_code, .reference_trim_rank, .regulator_fine_rank, .running, .core_tick
);

`default_nettype wire

// *** testbench/output_sink.sv ***
// Receiving controller model: collects every converter load and digital word
`timescale 1ns/10ps
`default_nettype none

module output_sink (
  // Clock
  input wire logic sys_clk,
  // Watched outputs
  input wire logic [11:0] dac_code,
  input wire logic dac_load,
  input wire logic [13:0] digital_value,
  input wire logic digital_valid,
  // Last received value
  output logic [13:0] seen_value,
  output logic seen_digital,
  output int seen_count
);
  initial seen_count = 0;

  // Converter codes widened to 14 bits so both paths compare alike
  always @(posedge sys_clk) begin
    if (dac_load || digital_valid) begin
      seen_value <= digital_valid ? digital_value : {dac_code, 2'b00};
      seen_digital <= digital_valid;
      seen_count <= seen_count + 1;
    end
  end
endmodule : output_sink

`default_nettype wire

// *** testbench/output_clip_limiter_tb.sv ***
// Self-checking bench for the output clip limiter
`timescale 1ns/10ps
`default_nettype none

module output_clip_limiter_tb;
  logic sys_clk, rst_b, supply_ok, reg_wr, reg_rd, bridge_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [13:0] bridge_value, digital_value, seen_value;
  logic [11:0] dac_code;
  logic dac_load, dac_href_1v, digital_valid, short_limit_en, regulator_target_5v5;
  logic [3:0] reference_trim_code, reference_trim_rank, regulator_fine_rank;
  logic running, core_tick, seen_digital;
  int seen_count, n_errors, num_checks, cycles, seed, up, low, hi_thr, lo_thr, c0, cfg, ex, v;
  int exp_q[$];
  int vals[5];

  output_clip_limiter #(.TICK_CYCLES(4)) dut (
    .sys_clk, .rst_b, .supply_ok, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bridge_value, .bridge_valid, .dac_code, .dac_load, .dac_href_1v, .digital_value,
    .digital_valid, .short_limit_en, .regulator_target_5v5, .reference_trim_code,
    .reference_trim_rank, .regulator_fine_rank, .running, .core_tick
  );

  output_sink sink (
    .sys_clk, .dac_code, .dac_load, .digital_value, .digital_valid, .seen_value,
    .seen_digital, .seen_count
  );

  // ----------------------------------------------------------------------
  // Bench model and bus tasks
  // ----------------------------------------------------------------------
  function automatic int clip(input int val);
    return val > hi_thr ? hi_thr : (val < lo_thr ? lo_thr : val);
  endfunction : clip

  function automatic int rank(input int c);
    return c < 8 ? 7 - c : 23 - c;
  endfunction : rank

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
    @(posedge sys_clk);
  endtask : rd

  // Waits a bounded time for the sink to see one update
  task automatic send(input int val);
    c0 = seen_count;
    bridge_value <= val[13:0];
    bridge_valid <= 1'b1;
    @(posedge sys_clk);
    bridge_valid <= 1'b0;
    for (int i = 0; i < 40 && seen_count == c0; i++) @(posedge sys_clk);
  endtask : send

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h0000_2235;
    {cycles, n_errors, num_checks} = 0;
    {rst_b, supply_ok, reg_wr, reg_rd, bridge_valid} = 0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    bridge_value = 14'h0000;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(8'h00, 32'h0000_007F, "clip_limits");
    rd(8'h04, 32'h0000_0004, "out_config");
    rd(8'h10, 32'h0000_0000, "unmapped");
    check("short_limit_en", 1, short_limit_en);
    check("trim_rank", 7, reference_trim_rank);
    send(32'h0000_3FFF);
    check("dropped", c0, seen_count);
    check("running", 0, running);
    supply_ok <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check("running", 1, running);
    for (int m = 0; m < 4; m++) begin
      cfg = ($random(seed) & 32'h0000_0F3C) | m;
      wr(8'h04, cfg);
      repeat (3) @(posedge sys_clk);
      check("short_limit_en", cfg[2], short_limit_en);
      check("target_5v5", cfg[5], regulator_target_5v5);
      check("trim_code", cfg[11:8], reference_trim_code);
      check("trim_rank", rank(cfg[11:8]), reference_trim_rank);
      check("fine_rank", rank(cfg[11:8]), regulator_fine_rank);
      check("href_1v", m == 2, dac_href_1v);
      for (int j = 0; j < 4; j++) begin
        up = j == 0 ? 0 : (j == 1 ? 127 : $random(seed) & 127);
        low = j == 0 ? 127 : (j == 1 ? 0 : $random(seed) & 127);
        wr(8'h00, (low << 8) | up);
        hi_thr = 'h3000 | (up << 5) | 'h1F;
        lo_thr = low << 5;
        rd(8'h0C, (lo_thr << 16) | hi_thr, "thresholds");
        vals = '{hi_thr, hi_thr + 1, lo_thr, lo_thr - 1, $random(seed)};
        foreach (vals[i]) begin
          v = vals[i] & 'h3FFF;
          exp_q.push_back(clip(v) & (m == 3 ? 'h3FFF : 'h3FFC));
          send(v);
          check("update_count", c0 + 1, seen_count);
          check("digital_path", m == 3, seen_digital);
          ex = exp_q.pop_front();
          check("output_value", ex, seen_value);
          ex = 32'h0004_0000 | (int'(v < lo_thr) << 17) | (int'(v > hi_thr) << 16) | clip(v);
          rd(8'h08, ex, "status");
        end
      end
    end
    close_out();
  end
endmodule : output_clip_limiter_tb

`default_nettype wire
